// File: logic/otb_regs.vh
// constants for the ook threshold and bit synchroniser receive block
`ifndef OTB_REGS_VH
`define OTB_REGS_VH

// ----------------------------------------
// chip operating modes
// ----------------------------------------
`define OTB_MODE_SLEEP 3'h0
`define OTB_MODE_STANDBY 3'h1
`define OTB_MODE_SYNTH 3'h2
`define OTB_MODE_RECEIVE 3'h3
`define OTB_MODE_TRANSMIT 3'h4

// ----------------------------------------
// data path modes
// ----------------------------------------
`define OTB_DP_CONTINUOUS 2'h0
`define OTB_DP_BUFFERED 2'h1

// ----------------------------------------
// threshold select codes
// ----------------------------------------
`define OTB_THR_FIXED 2'h0
`define OTB_THR_PEAK 2'h1

// ----------------------------------------
// scaling and timing
// ----------------------------------------
// strength units are 0.5 dB per count; 6 dB below peak
`define OTB_PEAK_DROP 9'h00C
// xtal cycles per chip are two to this power times (1 + divider)
`define OTB_CHIP_SHIFT 6
// transitions of 0101 preamble needed before lock (three bytes)
`define OTB_LOCK_EDGES 5'h17

`endif

// File: logic/otb_buf2.v
// two-entry valid/ready buffer in front of the fifo shift path
`timescale 1ns/100ps
module otb_buf2 #(
	parameter WIDTH = 1
) (
	input wire sys_clk,
	input wire rst_n,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);

	reg [WIDTH-1:0] mem [0:1];
	reg [1:0] full;
	wire push;
	wire pop;

	// ready is low only with both entries taken
	assign in_ready = ~full[1];
	assign push = in_valid & ~full[1];
	assign pop = full[0] & out_ready;
	assign out_data = mem[0];
	assign out_valid = full[0];

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem[0] <= {WIDTH{1'b0}};
			mem[1] <= {WIDTH{1'b0}};
			full <= 2'h0;
		end else begin
			if (pop) begin
				if (full[1]) begin
					mem[0] <= mem[1];
					full[1] <= 1'b0;
				end else if (push) begin
					mem[0] <= in_data;
				end else begin
					full[0] <= 1'b0;
				end
			end else if (push) begin
				if (!full[0]) begin
					mem[0] <= in_data;
					full[0] <= 1'b1;
				end else begin
					mem[1] <= in_data;
					full[1] <= 1'b1;
				end
			end
		end
	end

endmodule

// File: logic/otb_bitsync.v
// bit synchroniser: recovers chip timing from data transitions
`timescale 1ns/100ps
`include "otb_regs.vh"
module otb_bitsync (
	input wire sys_clk,
	input wire rst_n,
	input wire enable,
	input wire raw_bit,
	input wire [14:0] chip_len,
	output reg bit_data,
	output reg bit_strobe,
	output reg recovered_data_clock,
	output reg locked
);

	reg [14:0] phase;
	reg last_bit;
	reg [4:0] edges;
	wire [14:0] half;
	wire [14:0] last_phase;

	assign half = {1'b0, chip_len[14:1]};
	assign last_phase = chip_len - 15'h0001;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= 15'h0000;
			last_bit <= 1'b0;
			edges <= 5'h00;
			locked <= 1'b0;
			bit_data <= 1'b0;
			bit_strobe <= 1'b0;
			recovered_data_clock <= 1'b0;
		end else if (!enable) begin
			phase <= 15'h0000;
			last_bit <= raw_bit;
			edges <= 5'h00;
			locked <= 1'b0;
			bit_strobe <= 1'b0;
			recovered_data_clock <= 1'b0;
		end else begin
			last_bit <= raw_bit;
			bit_strobe <= 1'b0;
			if (raw_bit != last_bit) begin
				phase <= 15'h0001;
				recovered_data_clock <= 1'b0;
				if (edges != `OTB_LOCK_EDGES)
					edges <= edges + 5'h01;
				else
					locked <= 1'b1;
			end else begin
				if (phase >= last_phase) begin
					phase <= 15'h0000;
					recovered_data_clock <= 1'b0;
				end else begin
					phase <= phase + 15'h0001;
				end
				// rising clock edge at bit centre
				if (phase == half) begin
					bit_data <= raw_bit;
					bit_strobe <= locked;
					recovered_data_clock <= locked;
				end
			end
		end
	end

endmodule

// File: logic/otb_rx.v
// receive baseband: ook threshold demodulator, fsk polarity, bit sync and data routing
`timescale 1ns/100ps
`include "otb_regs.vh"

module otb_rx (
	input wire sys_clk,
	input wire rst_n,
	input wire [2:0] chip_operating_mode,
	input wire [1:0] data_path_mode,
	input wire modulation_ook,
	input wire [1:0] ook_threshold_select,
	input wire [2:0] threshold_decay_step,
	input wire [2:0] threshold_decay_period,
	input wire [7:0] threshold_floor_level,
	input wire [1:0] average_filter_cutoff,
	input wire bit_sync_disable,
	input wire [7:0] bit_rate_divider,
	input wire clock_out_enable,
	input wire strength_sample_clk,
	input wire [7:0] strength_value,
	input wire fsk_i_sign,
	input wire fsk_q_sign,
	output reg data_out,
	output reg data_oe,
	input wire irq1_in,
	output reg irq1_out,
	output reg irq1_oe,
	output wire fifo_bit_data,
	output wire fifo_bit_valid,
	input wire fifo_bit_ready,
	output reg clk_out,
	output reg clk_out_oe,
	output reg [7:0] threshold_level,
	output reg demod_bit,
	output reg bit_sync_locked,
	output reg bit_sync_active
);

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	reg [2:0] sclk_sync;
	reg [7:0] value_s1;
	reg [7:0] value_s2;
	reg [2:0] i_sync;
	reg [1:0] q_sync;
	reg [1:0] irq1_sync;
	wire sample_edge;
	wire i_rise;
	wire i_fall;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_sync <= 3'h0;
			value_s1 <= 8'h00;
			value_s2 <= 8'h00;
			i_sync <= 3'h0;
			q_sync <= 2'h0;
			irq1_sync <= 2'h3;
		end else begin
			sclk_sync <= {sclk_sync[1:0], strength_sample_clk};
			value_s1 <= strength_value;
			value_s2 <= value_s1;
			i_sync <= {i_sync[1:0], fsk_i_sign};
			q_sync <= {q_sync[0], fsk_q_sign};
			irq1_sync <= {irq1_sync[0], irq1_in};
		end
	end

	// value is two stages behind, so it has settled by the seen edge
	assign sample_edge = sclk_sync[1] & ~sclk_sync[2];
	assign i_rise = i_sync[1] & ~i_sync[2];
	assign i_fall = ~i_sync[1] & i_sync[2];

	// ----------------------------------------
	// mode decode
	// ----------------------------------------
	wire rx_on;
	wire continuous;
	wire sync_on;
	wire [14:0] chip_len;
	wire [8:0] div_plus;

	// only the receive code enables this path
	// counters, peak, average, demod bit and synchroniser gated by receive mode
	assign rx_on = (chip_operating_mode == `OTB_MODE_RECEIVE);
	// 00 continuous, anything else goes to the fifo
	assign continuous = (data_path_mode == `OTB_DP_CONTINUOUS);
	// bypass needs the disable bit set and irq pin low
	// buffered and packet ignore the disable bit
	assign sync_on = rx_on & (~continuous | ~(bit_sync_disable & ~irq1_sync[1]));
	assign div_plus = {1'b0, bit_rate_divider} + 9'h001;
	assign chip_len = {div_plus, {`OTB_CHIP_SHIFT{1'b0}}};

	// ----------------------------------------
	// chip and decay tick counters
	// ----------------------------------------
	reg [14:0] chip_cnt;
	reg [17:0] decay_cnt;
	reg [17:0] decay_len;
	wire chip_tick;
	wire decay_tick;

	always @* begin
		case (threshold_decay_period)
		3'h0: decay_len = {3'h0, chip_len};
		3'h1: decay_len = {2'h0, chip_len, 1'b0};
		3'h2: decay_len = {1'b0, chip_len, 2'h0};
		3'h3: decay_len = {chip_len, 3'h0};
		3'h4: decay_len = {4'h0, chip_len[14:1]};
		3'h5: decay_len = {5'h00, chip_len[14:2]};
		3'h6: decay_len = {6'h00, chip_len[14:3]};
		default: decay_len = {7'h00, chip_len[14:4]};
		endcase
	end

	assign chip_tick = (chip_cnt >= chip_len - 15'h0001);
	assign decay_tick = (decay_cnt >= decay_len - 18'h00001);

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			chip_cnt <= 15'h0000;
			decay_cnt <= 18'h00000;
		end else if (!rx_on) begin
			chip_cnt <= 15'h0000;
			decay_cnt <= 18'h00000;
		end else begin
			chip_cnt <= chip_tick ? 15'h0000 : chip_cnt + 15'h0001;
			decay_cnt <= decay_tick ? 18'h00000 : decay_cnt + 18'h00001;
		end
	end

	// ----------------------------------------
	// ook threshold
	// ----------------------------------------
	reg [7:0] peak;
	reg [7:0] strength;
	reg [11:0] avg;
	reg ook_bit;
	reg [8:0] step;
	reg [11:0] next_avg;
	reg [7:0] next_thr;
	wire [8:0] peak_min;
	wire [8:0] peak_less;
	wire [8:0] peak_drop;
	wire [11:0] strength_fix;
	wire [11:0] avg_diff;
	wire [3:0] avg_shift;

	always @* begin
		case (threshold_decay_step)
		3'h0: step = 9'h001;
		3'h1: step = 9'h002;
		3'h2: step = 9'h003;
		3'h3: step = 9'h004;
		3'h4: step = 9'h006;
		3'h5: step = 9'h008;
		3'h6: step = 9'h00A;
		default: step = 9'h00C;
		endcase
	end

	// highest peak that keeps the derived threshold at the floor
	assign peak_min = {1'b0, threshold_floor_level} + `OTB_PEAK_DROP;
	assign peak_less = {1'b0, peak} - step;
	// peak less 6 dB, saturating at zero
	assign peak_drop = ({1'b0, peak} > `OTB_PEAK_DROP) ? ({1'b0, peak} - `OTB_PEAK_DROP) : 9'h000;

	// one-pole filter stepped once per chip
	assign avg_shift = (average_filter_cutoff == 2'h0) ? 4'h2 :
		(average_filter_cutoff == 2'h3) ? 4'h4 : 4'h3;
	assign strength_fix = {strength, 4'h0};
	assign avg_diff = (strength_fix >= avg) ? (strength_fix - avg) : (avg - strength_fix);

	always @* begin
		next_avg = avg;
		if (chip_tick) begin
			if (strength_fix >= avg)
				next_avg = avg + (avg_diff >> avg_shift);
			else
				next_avg = avg - (avg_diff >> avg_shift);
		end
	end

	always @* begin
		case (ook_threshold_select)
		`OTB_THR_FIXED: next_thr = threshold_floor_level;
		`OTB_THR_PEAK: next_thr = (peak_drop[7:0] > threshold_floor_level) ?
			peak_drop[7:0] : threshold_floor_level;
		default: next_thr = avg[11:4];
		endcase
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			peak <= 8'h00;
			strength <= 8'h00;
			avg <= 12'h000;
			ook_bit <= 1'b0;
			threshold_level <= 8'h00;
		end else if (!rx_on) begin
			peak <= 8'h00;
			avg <= 12'h000;
			ook_bit <= 1'b0;
			threshold_level <= next_thr;
		end else begin
			threshold_level <= next_thr;
			avg <= next_avg;
			if (sample_edge) begin
				strength <= value_s2;
				// one when at or above the threshold
				ook_bit <= (value_s2 >= threshold_level);
			end
			if (sample_edge && value_s2 >= peak) begin
				peak <= value_s2;
			end else if (decay_tick && !ook_bit) begin
				// one decay step per period while zero
				// clamp so threshold rests at floor
				if ({1'b0, peak} >= step + peak_min)
					peak <= peak_less[7:0];
				else if ({1'b0, peak} > peak_min)
					peak <= peak_min[7:0];
			end
		end
	end

	// ----------------------------------------
	// fsk polarity and demodulated bit
	// ----------------------------------------
	reg fsk_bit;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fsk_bit <= 1'b0;
			demod_bit <= 1'b0;
		end else begin
			// polarity from which of i and q leads
			if (i_rise)
				fsk_bit <= q_sync[1];
			else if (i_fall)
				fsk_bit <= ~q_sync[1];
			demod_bit <= rx_on & (modulation_ook ? ook_bit : fsk_bit);
		end
	end

	// ----------------------------------------
	// bit synchroniser and fifo path
	// ----------------------------------------
	wire sync_data;
	wire sync_strobe;
	wire sync_recovered_data_clock;
	wire sync_locked;
	wire buf_ready;
	reg pend;
	reg pend_data;

	otb_bitsync u_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.enable(sync_on),
		.raw_bit(demod_bit),
		.chip_len(chip_len),
		.bit_data(sync_data),
		.bit_strobe(sync_strobe),
		.recovered_data_clock(sync_recovered_data_clock),
		.locked(sync_locked)
	);

	// a held bit waits here while the buffer is full
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend <= 1'b0;
			pend_data <= 1'b0;
		end else if (sync_strobe && !continuous) begin
			// synchronised bits go toward the fifo
			pend <= 1'b1;
			pend_data <= sync_data;
		end else if (pend && buf_ready) begin
			pend <= 1'b0;
		end
	end

	otb_buf2 #(
		.WIDTH(1)
	) u_buf (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.in_data(pend_data),
		.in_valid(pend),
		.in_ready(buf_ready),
		.out_data(fifo_bit_data),
		.out_valid(fifo_bit_valid),
		.out_ready(fifo_bit_ready)
	);

	// ----------------------------------------
	// pins
	// ----------------------------------------
	wire clk_run;

	// clock output needs enable and any mode but sleep
	assign clk_run = clock_out_enable & (chip_operating_mode != `OTB_MODE_SLEEP);

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			data_out <= 1'b0;
			data_oe <= 1'b0;
			irq1_out <= 1'b0;
			irq1_oe <= 1'b0;
			clk_out <= 1'b0;
			clk_out_oe <= 1'b0;
			bit_sync_locked <= 1'b0;
			bit_sync_active <= 1'b0;
		end else begin
			// continuous receive drives the data pin
			data_oe <= rx_on & continuous;
			data_out <= sync_on ? sync_data : demod_bit;
			// recovered clock on irq pin one
			irq1_oe <= rx_on & continuous & ~bit_sync_disable;
			irq1_out <= sync_recovered_data_clock;
			clk_out_oe <= (chip_operating_mode != `OTB_MODE_SLEEP);
			clk_out <= clk_run & ~clk_out;
			bit_sync_locked <= sync_locked;
			bit_sync_active <= sync_on;
		end
	end

endmodule

// File: test/otb_rx_chk.sv
// assertion checker for the receive baseband block
`timescale 1ns/100ps
module otb_rx_chk (
	input wire sys_clk,
	input wire rst_n,
	input wire [2:0] chip_operating_mode,
	input wire [1:0] data_path_mode,
	input wire [1:0] ook_threshold_select,
	input wire [7:0] threshold_floor_level,
	input wire bit_sync_disable,
	input wire clock_out_enable,
	input wire data_oe,
	input wire irq1_out,
	input wire irq1_oe,
	input wire fifo_bit_data,
	input wire fifo_bit_valid,
	input wire fifo_bit_ready,
	input wire clk_out,
	input wire clk_out_oe,
	input wire [7:0] threshold_level,
	input wire demod_bit,
	input wire bit_sync_locked,
	input wire bit_sync_active
);
	wire rx = chip_operating_mode == 3'h3;
	default clocking dc @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	// ----
	// properties
	// ----
	a_sleep_clk_off: assert property (chip_operating_mode == 3'h0 |=> !clk_out_oe)
		else $error("clock pin driven in sleep");
	a_clk_runs: assert property ((clock_out_enable && chip_operating_mode != 3'h0)[*3]
		|-> clk_out != $past(clk_out)) else $error("clock output not toggling");
	a_rx_only_demod: assert property ((!rx)[*4] |-> !demod_bit)
		else $error("demodulator active outside receive");
	a_rx_only_sync: assert property ((!rx)[*2] |-> !bit_sync_active)
		else $error("synchroniser active outside receive");
	a_sync_forced: assert property ((rx && data_path_mode != 2'h0)[*2] |-> bit_sync_active)
		else $error("synchroniser not forced on");
	a_fixed_thr: assert property ((rx && ook_threshold_select == 2'h0)[*2]
		|-> threshold_level == $past(threshold_floor_level)) else $error("fixed threshold wrong");
	a_peak_floor: assert property ((rx && ook_threshold_select == 2'h1)[*2]
		|-> threshold_level >= $past(threshold_floor_level)) else $error("peak below floor");
	a_data_pin_oe: assert property (!(rx && data_path_mode == 2'h0) |=> !data_oe)
		else $error("data pin driven off continuous receive");
	a_bypass_no_clk: assert property (bit_sync_disable |=> !irq1_oe)
		else $error("irq pin driven while bypassed");
	a_fifo_hold: assert property (rx && fifo_bit_valid && !fifo_bit_ready
		|=> fifo_bit_valid && fifo_bit_data == $past(fifo_bit_data)) else $error("bit lost");
	a_recovered_data_clock_locked: assert property ($rose(irq1_out) |-> bit_sync_locked)
		else $error("recovered clock before lock");
endmodule

bind otb_rx otb_rx_chk otb_rx_chk_inst (.sys_clk, .rst_n, .chip_operating_mode,
	.data_path_mode, .ook_threshold_select, .threshold_floor_level, .bit_sync_disable,
	.clock_out_enable, .data_oe, .irq1_out, .irq1_oe, .fifo_bit_data, .fifo_bit_valid,
	.fifo_bit_ready, .clk_out, .clk_out_oe, .threshold_level, .demod_bit,
	.bit_sync_locked, .bit_sync_active);

// File: test/otb_host.sv
// host model: takes serial data on recovered clock rises
`timescale 1ns/100ps
module otb_host (
	input wire data_out,
	input wire data_oe,
	input wire irq1_out,
	input wire irq1_oe,
	input wire hold_low,
	output wire irq1_pin,
	output reg got_bit,
	output reg [15:0] got_count
);
	// undriven data pin floats: show the inverse so stale values never match
	wire data_pin = data_oe ? data_out : ~got_bit;
	// host holds pin low to bypass, else pull-up
	assign irq1_pin = irq1_oe ? irq1_out : !hold_low;
	initial got_bit = 1'b0;
	initial got_count = 16'h0000;
	// bit taken at recovered clock rise
	// data pin and clock leave the same flop stage, so read once both have settled
	always @(posedge irq1_pin) begin
		#1;
		if (irq1_oe) begin
			got_bit = data_pin;
			got_count = got_count + 16'h0001;
		end
	end
endmodule

// File: test/testbench.sv
// self-checking bench for the receive baseband block
`timescale 1ns/100ps
module testbench;
	reg sys_clk = 1'b0, rst_n = 1'b0, modulation_ook = 1'b1, bit_sync_disable = 1'b0;
	reg clock_out_enable = 1'b1, strength_sample_clk = 1'b0, fsk_i_sign = 1'b0;
	reg fsk_q_sign = 1'b0, fifo_bit_ready = 1'b1, hold_low = 1'b0, armed = 1'b0;
	reg [2:0] chip_operating_mode = 3'h3, threshold_decay_step = 3'h0;
	reg [2:0] threshold_decay_period = 3'h0;
	reg [1:0] data_path_mode = 2'h0, ook_threshold_select = 2'h0, average_filter_cutoff = 2'h0;
	reg [7:0] threshold_floor_level = 8'h64, bit_rate_divider = 8'h00, strength_value = 8'h00;
	reg [31:0] seed = 32'hCB63C083;
	wire data_out, data_oe, irq1_in, irq1_out, irq1_oe, fifo_bit_data, fifo_bit_valid;
	wire clk_out, clk_out_oe, demod_bit, bit_sync_locked, bit_sync_active, got_bit;
	wire [7:0] threshold_level;
	wire [15:0] got_count;
	integer failures = 0, tests_run = 0, cycles = 0, k;
	reg exp_q[$];
	otb_rx otb_rx_inst (.sys_clk, .rst_n, .chip_operating_mode, .data_path_mode,
		.modulation_ook, .ook_threshold_select, .threshold_decay_step, .threshold_decay_period,
		.threshold_floor_level, .average_filter_cutoff, .bit_sync_disable, .bit_rate_divider,
		.clock_out_enable, .strength_sample_clk, .strength_value, .fsk_i_sign, .fsk_q_sign,
		.data_out, .data_oe, .irq1_in, .irq1_out, .irq1_oe, .fifo_bit_data, .fifo_bit_valid,
		.fifo_bit_ready, .clk_out, .clk_out_oe, .threshold_level, .demod_bit,
		.bit_sync_locked, .bit_sync_active);
	otb_host otb_host_inst (.data_out, .data_oe, .irq1_out, .irq1_oe, .hold_low,
		.irq1_pin(irq1_in), .got_bit, .got_count);
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	// sample clock offset so its edges stay at a fixed phase clear of sys_clk edges
	initial begin
		#3.3;
		forever #16 strength_sample_clk = ~strength_sample_clk;
	end
	function [31:0] xs(input [31:0] v);
		reg [31:0] t;
		begin
			t = v ^ (v << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction
	task check(input [15:0] seen, input [15:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task final_report;
		begin
			$display("comparisons %0d mismatches %0d", tests_run, failures);
			if (failures == 0 && tests_run > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(negedge sys_clk);
	endtask
	// ----
	// result monitor: oldest note against each bit delivered
	// ----
	task take(input b);
		begin
			if (exp_q.size() == 0)
				check(16'h0001, 16'h0000);
			else
				check(b, exp_q.pop_front());
		end
	endtask
	always @(posedge sys_clk) begin
		cycles = cycles + 1;
		if (cycles > 90000) begin
			failures = failures + 1;
			final_report;
		end
		if (armed && data_path_mode != 2'h0 && fifo_bit_valid && fifo_bit_ready)
			take(fifo_bit_data);
	end
	always @(got_count) begin
		if (armed && data_path_mode == 2'h0)
			take(got_bit);
	end
	// ----
	// stimulus
	// ----
	task decay(input [2:0] p, input [2:0] s);
		integer d, st;
		begin
			threshold_decay_period = p;
			threshold_decay_step = s;
			strength_value = 8'hFA;
			cyc(64);
			strength_value = 8'h00;
			cyc(1280);
			st = (s < 4) ? s + 1 : 2 * s - 2;
			d = ((p < 4) ? (20 >> p) : (20 << (p - 3))) * st;
			d = (d > 238) ? 0 : 238 - d;
			check(threshold_level + 2 * st >= d && threshold_level <= d + 2 * st, 1);
		end
	endtask
	task stream(input [1:0] dp, input [7:0] dv);
		integer n;
		reg b;
		begin
			data_path_mode = dp;
			bit_rate_divider = dv;
			bit_sync_disable = dp != 2'h0;
			for (n = 0; n < 56; n = n + 1) begin
				seed = xs(seed);
				// four bytes of alternating preamble first
				b = (n < 32) ? n[0] : seed[0];
				strength_value = b ? 8'hC8 : 8'h00;
				if (n == 32) begin
					check(bit_sync_locked, 1);
					check(data_oe, dp == 2'h0);
					check(bit_sync_active, 1);
					armed = 1'b1;
				end
				if (armed)
					exp_q.push_back(b);
				// one three-chip stall fills the buffer, then single-chip stalls
				fifo_bit_ready = (n < 40 || n > 42) && !(n > 44 && n[0] && seed[1]);
				cyc(64 * (dv + 1));
			end
			fifo_bit_ready = 1'b1;
			cyc(8);
			armed = 1'b0;
			check(exp_q.size(), 0);
		end
	endtask
	initial begin
		cyc(4);
		check({demod_bit, fifo_bit_valid, irq1_oe, data_oe}, 0);
		rst_n = 1'b1;
		cyc(8);
		for (k = 0; k < 5; k = k + 1) begin
			chip_operating_mode = k;
			clock_out_enable = k[0];
			strength_value = 8'hC8;
			cyc(32);
			check(demod_bit, k == 3);
			check(clk_out_oe, k != 0);
		end
		chip_operating_mode = 3'h3;
		for (k = 0; k < 16; k = k + 1) begin
			seed = xs(seed);
			threshold_floor_level = seed[7:0];
			strength_value = seed[15:8];
			cyc(16);
			check(threshold_level, seed[7:0]);
			check(demod_bit, seed[15:8] >= seed[7:0]);
		end
		modulation_ook = 1'b0;
		for (k = 0; k < 4; k = k + 1) begin
			fsk_q_sign = k[1];
			cyc(4);
			fsk_i_sign = ~k[0];
			cyc(8);
			check(demod_bit, k[1] ^ k[0]);
		end
		modulation_ook = 1'b1;
		threshold_floor_level = 8'h64;
		bit_sync_disable = 1'b1;
		hold_low = 1'b1;
		for (k = 0; k < 2; k = k + 1) begin
			strength_value = k[0] ? 8'hC8 : 8'h00;
			cyc(32);
			check({bit_sync_active, irq1_oe, data_out}, k[0]);
		end
		hold_low = 1'b0;
		bit_sync_disable = 1'b0;
		threshold_floor_level = 8'h00;
		ook_threshold_select = 2'h1;
		threshold_decay_period = 3'h3;
		strength_value = 8'hFA;
		cyc(32);
		check(threshold_level, 8'hEE);
		for (k = 0; k < 8; k = k + 1)
			decay(k, 0);
		for (k = 1; k < 8; k = k + 1)
			decay(0, k);
		strength_value = 8'h78;
		for (k = 0; k < 4; k = k + 1) begin
			average_filter_cutoff = k;
			ook_threshold_select = {1'b1, k[1]};
			cyc(4000);
			check(threshold_level >= 8'h68 && threshold_level <= 8'h78, 1);
		end
		ook_threshold_select = 2'h0;
		threshold_floor_level = 8'h64;
		stream(2'h0, 8'h00);
		stream(2'h1, 8'h00);
		stream(2'h2, 8'h01);
		final_report;
	end
endmodule
